// [design/cds_pkg.sv]
// Purpose: shared constants of the companion die supervisor
// Assumes: 250 MHz core clock, classic Wishbone register access
// Notes: offsets are byte addresses of 32-bit words
package cds_pkg;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 10;
  localparam int TICK_DIV = TICK_US * CLK_MHZ;
  localparam int NORMREQ_MS = 80;
  localparam int RST_HOLD_US = 1250;
  localparam int WD_BASE_MS = 10;
  localparam logic [7:0] ONE_MS_TICKS = 8'(1000 / TICK_US);
  localparam logic [15:0] NORMREQ_TICKS = 16'(NORMREQ_MS * 1000 / TICK_US);
  localparam logic [15:0] RST_HOLD_TICKS = 16'(RST_HOLD_US / TICK_US);
  localparam logic [15:0] WD_BASE_TICKS = 16'(WD_BASE_MS * 1000 / TICK_US);
  // ---------------------------------------------
  // register map
  // ---------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MUX = 8'h04;
  localparam logic [7:0] ADDR_CAUSE = 8'h08;
  localparam logic [7:0] ADDR_IFLAG = 8'h0C;
  localparam logic [7:0] ADDR_IMASK = 8'h10;
  localparam logic [7:0] ADDR_WDSVC = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // control fields
  localparam int CTRL_POWER_STAGE_ON_BIT = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_WDEN = 2;
  localparam int CTRL_WDP = 3;
  localparam int CTRL_HALL = 5;
  localparam int CTRL_HSPWM = 6;
  localparam int CTRL_HSON = 9;
  // analog mux control fields
  localparam int MUX_SS = 0;
  localparam int MUX_CS = 4;
  localparam logic [3:0] MUX_SRC_COUNT = 4'hB;
  // cause bits
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_WD = 1;
  localparam int CAUSE_WAKE = 2;
  localparam int CAUSE_EXT = 3;
  // interrupt bits
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_TOUT = 1;
  localparam int IRQ_WDERR = 2;
  localparam logic [15:0] WD_KEY = 16'hA55A;
  typedef enum logic [2:0] {CDS_RESET, CDS_NORMREQ, CDS_RUN, CDS_SLEEP, CDS_TEST} cds_state_e;
endpackage

// [design/cds_tick_gen.sv]
// Purpose: divides the core clock into a 10 us enable pulse
// Assumes: one clock domain
// Notes: pulse is one cycle wide
`timescale 1ns/1ps
`default_nettype none
module cds_tick_gen
  import cds_pkg::*;
#(
  // cycles per enable pulse
  parameter int DIV = TICK_DIV
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // enable out
  output logic tick
);
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic next_tick;
  always_comb
  begin
    next_tick = (cnt == 12'(DIV - 1));
    next_cnt = next_tick ? 12'h000 : cnt + 12'h001;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cnt <= 12'h000;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// [design/cds_supervisor.sv]
// Purpose: supervisory logic of the companion die
// Assumes: classic Wishbone slave, one 250 MHz clock, open-drain pins as in/out/oe
// Notes: oe low means the pin is driven low
//
// Operation
// - if bit unset when timeout expires, enter sleep mode.
// - strap high gives test mode: timeout off, bus receiver off.
// - both edges of the wake input are wake events.
// - reset line is open-drain two-way, either side may pull low.
// - wake events outside sleep and timeout events enabled in the mask pull the open-drain interrupt line low.
// - watchdog resets on expiry and on wrong service.
// - watchdog reset clears all registers except the reset-cause register.
// - four-bit select routes one of eleven sources to converter output.
// - current source has four values plus off.
// - high-side switch uses self PWM or follows external PWM input.
// - microcontroller masters serial port and PWM line.
// - hall input is general input or two/three-pin hall sensor.
// - watchdog period codes 00..11 give 80, 40, 20, 10 ms.
// - after supply rise, hold reset low about 1.25 ms.
`timescale 1ns/1ps
`default_nettype none
module cds_supervisor
  import cds_pkg::*;
#(
  // cycles per tick; a bench may shorten it, every count stays in ticks
  parameter int TICK_CYCLES = TICK_DIV
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins from outside
  input wire logic wake_input,
  input wire logic factory_test_strap,
  input wire logic hall_input,
  input wire logic pwm_in,
  // open-drain reset line
  input wire logic rst_line_in,
  output logic rst_line_out,
  output logic rst_line_oe,
  // open-drain interrupt line
  output logic irq_line_out,
  output logic irq_line_oe,
  // analog and power control
  output logic [3:0] analog_mux_sel,
  output logic [2:0] current_src_sel,
  output logic [2:0] high_side_switch,
  output logic hall_sensor_mode,
  output logic hall_level,
  output logic bus_rx_enable,
  output logic sleep_mode,
  output logic irq
);
  // ---------------------------------------------
  // synchronisers and tick
  // ---------------------------------------------
  logic tick;
  logic [2:0] s_wake, s_strap, s_hall, s_rst, s_pwm;
  logic wake_q, strap_q, hall_q, rst_q, pwm_q;
  cds_tick_gen #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(tick)
  );
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    // a change counts once the second and third stages agree
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  cds_state_e state, next_state;
  logic [15:0] tcnt, next_tcnt;
  logic [15:0] wdcnt, next_wdcnt;
  logic [11:0] ctrl, next_ctrl;
  logic [6:0] muxr, next_muxr;
  logic [3:0] cause, next_cause;
  logic [2:0] iflag, next_iflag, imask, next_imask;
  logic [2:0] pcnt, next_pcnt;
  logic ack_n, wd_rst, wd_err, wd_exp, tout, wake_ev, ext_rst;
  logic [31:0] rdata;
  logic wr, rd_hit;
  logic [15:0] wd_period;
  // a write lands at the edge where the master samples ack high
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign ack_n = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // watchdog period 80 ms at code 00, halving per code
  assign wd_period = WD_BASE_TICKS << (2'h3 - ctrl[CTRL_WDP +: 2]);
  // ignored while reset is held: the synchroniser may still be filling from its reset value
  assign wake_ev = (state != CDS_RESET) && (s_wake[1] == s_wake[2]) && (s_wake[2] != wake_q);
  // falling edge only: the level alone would fire while our own release is still in the synchroniser
  assign ext_rst = (state != CDS_RESET) && (state != CDS_SLEEP) && rst_q && (s_rst[1] == s_rst[2]) && !s_rst[2];
  always_comb
  begin
    next_state = state;
    next_tcnt = tcnt;
    next_wdcnt = wdcnt;
    wd_exp = 1'b0;
    wd_err = 1'b0;
    tout = 1'b0;
    unique case (state)
      CDS_RESET:
      begin
        // hold reset low 1.25 ms after supply or reset cause
        if (tick)
          next_tcnt = tcnt + 16'h0001;
        if (tcnt >= RST_HOLD_TICKS)
        begin
          next_tcnt = 16'h0000;
          next_state = strap_q ? CDS_TEST : CDS_NORMREQ;
        end
      end
      CDS_NORMREQ:
      begin
        if (tick)
          next_tcnt = tcnt + 16'h0001;
        if (ctrl[CTRL_POWER_STAGE_ON_BIT])
          next_state = CDS_RUN;
        else if (strap_q)
          next_state = CDS_TEST;
        else if (tcnt >= NORMREQ_TICKS)
        begin
          tout = 1'b1;
          next_state = CDS_SLEEP;
        end
      end
      CDS_RUN:
      begin
        if (ctrl[CTRL_SLEEP])
          next_state = CDS_SLEEP;
        else if (ctrl[CTRL_WDEN] && tick)
        begin
          next_wdcnt = wdcnt + 16'h0001;
          if (wdcnt + 16'h0001 >= wd_period)
            wd_exp = 1'b1;
        end
        // early or wrong key service is an error
        if (wr && wb_adr_i == ADDR_WDSVC && ctrl[CTRL_WDEN])
        begin
          if (wb_dat_i[15:0] != WD_KEY || wdcnt < (wd_period >> 1))
            wd_err = 1'b1;
          next_wdcnt = 16'h0000;
        end
        if (wd_exp || wd_err)
        begin
          next_state = CDS_RESET;
          next_tcnt = 16'h0000;
        end
      end
      CDS_SLEEP:
        if (wake_ev)
        begin
          next_state = CDS_RESET;
          next_tcnt = 16'h0000;
        end
      CDS_TEST:
        if (!strap_q)
        begin
          next_state = CDS_NORMREQ;
          next_tcnt = 16'h0000;
        end
    endcase
    if (ext_rst && state != CDS_SLEEP)
    begin
      next_state = CDS_RESET;
      next_tcnt = 16'h0000;
    end
    if (state != CDS_RUN)
      next_wdcnt = 16'h0000;
  end
  assign wd_rst = wd_exp || wd_err;
  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_muxr = muxr;
    next_imask = imask;
    next_cause = cause;
    next_iflag = iflag;
    if (wr)
      unique case (wb_adr_i)
        ADDR_CTRL:
          if (wb_sel_i[0] && wb_sel_i[1])
            next_ctrl = wb_dat_i[11:0];
        ADDR_MUX:
          if (wb_sel_i[0] && wb_dat_i[3:0] < MUX_SRC_COUNT)
            next_muxr = wb_dat_i[6:0];
        ADDR_CAUSE:
          if (wb_sel_i[0])
            next_cause = cause & ~wb_dat_i[3:0];
        ADDR_IFLAG:
          if (wb_sel_i[0])
            next_iflag = iflag & ~wb_dat_i[2:0];
        ADDR_IMASK:
          if (wb_sel_i[0])
            next_imask = wb_dat_i[2:0];
        default:
          next_ctrl = next_ctrl;
      endcase
    // events win over software clears
    next_iflag[IRQ_WAKE] = next_iflag[IRQ_WAKE] | wake_ev;
    next_iflag[IRQ_TOUT] = next_iflag[IRQ_TOUT] | tout;
    next_iflag[IRQ_WDERR] = next_iflag[IRQ_WDERR] | wd_err;
    next_cause[CAUSE_WD] = next_cause[CAUSE_WD] | wd_rst;
    next_cause[CAUSE_WAKE] = next_cause[CAUSE_WAKE] | (state == CDS_SLEEP && wake_ev);
    next_cause[CAUSE_EXT] = next_cause[CAUSE_EXT] | ext_rst;
    if (next_state == CDS_RESET && state != CDS_RESET)
    begin
      next_ctrl = '0;
      next_muxr = '0;
      next_imask = '0;
      next_iflag = '0;
    end
    // self PWM: 1 of 8 ticks duty while inrush limited
    next_pcnt = tick ? pcnt + 3'h1 : pcnt;
  end
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (wb_adr_i)
      ADDR_CTRL: rdata = {20'h00000, ctrl};
      ADDR_MUX: rdata = {25'h0000000, muxr};
      ADDR_CAUSE: rdata = {28'h0000000, cause};
      ADDR_IFLAG: rdata = {29'h00000000, iflag};
      ADDR_IMASK: rdata = {29'h00000000, imask};
      ADDR_STATUS: rdata = {27'h0000000, hall_q, pwm_q, wake_q, strap_q, state == CDS_RUN};
      default:
      begin
        rdata = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      {s_wake, s_strap, s_hall, s_rst, s_pwm} <= 15'h0000;
      {wake_q, strap_q, hall_q, rst_q, pwm_q} <= 5'h00;
      state <= CDS_RESET;
      tcnt <= 16'h0000;
      wdcnt <= 16'h0000;
      ctrl <= 12'h000;
      muxr <= 7'h00;
      cause <= 4'h1;
      iflag <= 3'h0;
      imask <= 3'h0;
      pcnt <= 3'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      rst_line_out <= 1'b0;
      rst_line_oe <= 1'b0;
      irq_line_out <= 1'b0;
      irq_line_oe <= 1'b1;
      analog_mux_sel <= 4'h0;
      current_src_sel <= 3'h0;
      high_side_switch <= 3'h0;
      hall_sensor_mode <= 1'b0;
      hall_level <= 1'b0;
      bus_rx_enable <= 1'b0;
      sleep_mode <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      s_wake <= {s_wake[1:0], wake_input};
      s_strap <= {s_strap[1:0], factory_test_strap};
      s_hall <= {s_hall[1:0], hall_input};
      s_rst <= {s_rst[1:0], rst_line_in};
      s_pwm <= {s_pwm[1:0], pwm_in};
      wake_q <= agreed(s_wake, wake_q);
      strap_q <= agreed(s_strap, strap_q);
      hall_q <= agreed(s_hall, hall_q);
      rst_q <= agreed(s_rst, rst_q);
      pwm_q <= agreed(s_pwm, pwm_q);
      state <= next_state;
      tcnt <= next_tcnt;
      wdcnt <= next_wdcnt;
      ctrl <= next_ctrl;
      muxr <= next_muxr;
      cause <= next_cause;
      iflag <= next_iflag;
      imask <= next_imask;
      pcnt <= next_pcnt;
      wb_ack_o <= ack_n;
      wb_dat_o <= (ack_n && !wb_we_i && rd_hit) ? rdata : 32'h00000000;
      rst_line_out <= 1'b0;
      rst_line_oe <= !(next_state == CDS_RESET || next_state == CDS_SLEEP);
      irq_line_out <= 1'b0;
      irq_line_oe <= !(|(next_iflag & next_imask));
      irq <= |(next_iflag & next_imask);
      analog_mux_sel <= next_muxr[MUX_SS +: 4];
      current_src_sel <= next_muxr[MUX_CS +: 3];
      hall_sensor_mode <= next_ctrl[CTRL_HALL];
      hall_level <= hall_q;
      bus_rx_enable <= next_state == CDS_RUN && !strap_q;
      sleep_mode <= next_state == CDS_SLEEP;
      for (int i = 0; i < 3; i++)
        high_side_switch[i] <= (next_state == CDS_RUN) && next_ctrl[CTRL_HSON + i] &&
          (next_ctrl[CTRL_HSPWM + i] ? pwm_q : (next_pcnt == 3'h0));
    end
  end
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  AST_TOUT_SLEEP: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == CDS_NORMREQ && !ctrl[CTRL_POWER_STAGE_ON_BIT] && !strap_q && !ext_rst && tcnt >= NORMREQ_TICKS)
    |=> state == CDS_SLEEP) else $error("timeout did not sleep");
  AST_TEST_NO_RX: assert property (@(posedge core_clk) disable iff (!rstn)
    state == CDS_TEST |=> !bus_rx_enable) else $error("receiver on in test");
  AST_WAKE_EDGE: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == CDS_SLEEP && wake_ev && !ext_rst) |=> state == CDS_RESET) else $error("wake missed");
  AST_RST_LOW: assert property (@(posedge core_clk) disable iff (!rstn)
    state == CDS_RESET |-> !rst_line_oe) else $error("reset line released in reset");
  AST_IRQ_PIN: assert property (@(posedge core_clk) disable iff (!rstn)
    irq |-> !irq_line_oe) else $error("irq pin not low");
  AST_WD_ERR: assert property (@(posedge core_clk) disable iff (!rstn)
    wd_err |=> state == CDS_RESET) else $error("bad service no reset");
  AST_WD_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn)
    wd_rst |=> (ctrl == 12'h000 && cause[CAUSE_WD])) else $error("watchdog reset clear wrong");
  AST_MUX_RANGE: assert property (@(posedge core_clk) disable iff (!rstn)
    analog_mux_sel < MUX_SRC_COUNT) else $error("mux select out of range");
  AST_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == CDS_RESET && tcnt < RST_HOLD_TICKS) |=> state == CDS_RESET)
    else $error("reset released early");
  AST_POWER_STAGE_ON_BIT_STOP: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == CDS_NORMREQ && ctrl[CTRL_POWER_STAGE_ON_BIT] && !ext_rst) |=> state == CDS_RUN) else $error("power_stage_on_bit ignored");
endmodule
`default_nettype wire

// [test/cds_mcu_model.sv]
// Purpose: microcontroller core model, master of the register bus and pwm line
// Assumes: die answers each bus request with a one-cycle ack
// Notes: ok stays low when no ack comes within the bound
`timescale 1ns/1ps
`default_nettype none
module cds_mcu_model
(
  // clock
  input wire logic core_clk,
  // bus master
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat_w,
  input wire logic [31:0] dat_r,
  input wire logic ack,
  // pwm line
  output logic pwm
);
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
    pwm = 1'b0;
  end
  // request held until ack is sampled, released at that same edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = 32'h0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    while (!ok && n < 50)
    begin
      @(posedge core_clk);
      n++;
      ok = (ack === 1'b1);
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic set_pwm(input logic v);
    @(posedge core_clk);
    pwm <= v;
  endtask
endmodule
`default_nettype wire

// [test/cds_supervisor_tb_top.sv]
// Purpose: self-checking bench of the supervisor
// Assumes: the tick is shortened to a few cycles so every timeout fits in a short run
// Notes: expectations come from the package constants
`timescale 1ns/1ps
`default_nettype none
module cds_supervisor_tb_top;
  import cds_pkg::*;
  logic core_clk, rstn, wake_input, factory_test_strap, hall_input, mcu_rst_oe;
  logic cyc, stb, we, ack, pwm, rst_line_out, rst_line_oe, irq_line_out, irq_line_oe;
  logic hall_sensor_mode, hall_level, bus_rx_enable, sleep_mode, irq;
  logic [7:0] adr;
  logic [3:0] sel, analog_mux_sel;
  logic [31:0] dat_w, dat_r, seed, q, c;
  logic [2:0] current_src_sel, high_side_switch;
  logic [6:0] m, r;
  wire logic rst_wire;
  int error_cnt, compares;
  int hi;
  // all counts stay in ticks, only the tick is shorter
  localparam int TB_TICK = 4;
  // pull-up line: either party pulls it low
  assign rst_wire = rst_line_oe & mcu_rst_oe;
  cds_mcu_model mcu_u (.core_clk, .cyc, .stb, .we, .adr, .sel, .dat_w, .dat_r, .ack, .pwm);
  cds_supervisor #(.TICK_CYCLES(TB_TICK)) dut_u (.core_clk, .rstn, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .wake_input, .factory_test_strap, .hall_input, .pwm_in(pwm), .rst_line_in(rst_wire),
    .rst_line_out, .rst_line_oe, .irq_line_out, .irq_line_oe, .analog_mux_sel,
    .current_src_sel, .high_side_switch, .hall_sensor_mode, .hall_level, .bus_rx_enable,
    .sleep_mode, .irq);
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // a source code past the last one is refused and the old setting stays
  function automatic logic [6:0] mux_exp(input logic [6:0] old, input logic [6:0] req);
    return (req[3:0] < MUX_SRC_COUNT) ? req : old;
  endfunction
  task automatic conclude();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    mcu_u.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      chk(0, 1, "bus timeout");
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    chk(q & msk, e, s);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim, input string w);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    if (s !== v)
    begin
      chk(0, 1, w);
      conclude();
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge core_clk);
  endtask
  // ---------------------------------------------
  // sequence
  // ---------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    rstn = 1'b0;
    wake_input = 1'b0;
    factory_test_strap = 1'b0;
    hall_input = 1'b0;
    mcu_rst_oe = 1'b1;
    seed = 32'h86FC;
    error_cnt = 0;
    compares = 0;
    repeat (4) @(posedge core_clk);
    chk(rst_line_oe, 1'b0, "reset line low");
    chk(irq_line_oe, 1'b1, "irq line idle");
    rstn <= 1'b1;
    rd(ADDR_CAUSE, 32'hF, 32'h1 << CAUSE_POR, "power-on cause");
    bus(1'b1, ADDR_CAUSE, 32'hF);
    repeat ((RST_HOLD_TICKS - 5) * TB_TICK) @(posedge core_clk);
    chk(rst_line_oe, 1'b0, "reset hold");
    wait_lvl(rst_line_oe, 1'b1, 8 * TB_TICK, "reset release");
    m = 7'h00;
    for (int i = 0; i < 16; i++)
    begin
      r = {3'(rnd() % 5), 4'(i)};
      m = mux_exp(m, r);
      bus(1'b1, ADDR_MUX, 32'(r));
      repeat (2) @(posedge core_clk);
      chk(analog_mux_sel, m[3:0], "mux source");
      chk(current_src_sel, m[6:4], "current value");
    end
    rd(ADDR_MUX, 32'h7F, 32'(m), "mux readback");
    c = (1 << CTRL_POWER_STAGE_ON_BIT) | (1 << CTRL_WDEN) | (3 << CTRL_WDP) | (1 << CTRL_HALL) | (1 << CTRL_HSPWM);
    c = c | (1 << CTRL_HSON) | (1 << (CTRL_HSON + 1));
    bus(1'b1, ADDR_CTRL, c);
    rd(ADDR_STATUS, 32'h1, 32'h1, "run state");
    @(posedge core_clk);
    hall_input <= rnd() & 1;
    mcu_u.set_pwm(1'b1);
    settle();
    chk(hall_sensor_mode, 1'b1, "hall mode");
    rd(ADDR_STATUS, 32'h10, 32'(hall_input) << 4, "hall level");
    chk(high_side_switch[0], 1'b1, "switch follows pwm");
    mcu_u.set_pwm(1'b0);
    settle();
    chk(high_side_switch[0], 1'b0, "switch follows pwm");
    // self pwm is on for one tick in eight
    hi = 0;
    for (int k = 0; k < 8 * TB_TICK; k++)
    begin
      @(posedge core_clk);
      hi += high_side_switch[1];
    end
    chk(hi, TB_TICK, "self pwm duty");
    for (int e = 0; e < 2; e++)
    begin
      @(posedge core_clk);
      wake_input <= ~wake_input;
      settle();
      rd(ADDR_IFLAG, 32'h1, 32'h1, "wake edge");
      chk(irq, 1'b0, "masked irq");
      bus(1'b1, ADDR_IFLAG, 32'h1);
    end
    bus(1'b1, ADDR_IMASK, 32'h1 << IRQ_WAKE);
    @(posedge core_clk);
    wake_input <= ~wake_input;
    settle();
    chk(irq, 1'b1, "irq level");
    chk(irq_line_oe, 1'b0, "irq line pulled");
    bus(1'b1, ADDR_IFLAG, 32'h1);
    settle();
    chk(irq_line_oe, 1'b1, "irq line released");
    chk(bus_rx_enable, 1'b1, "receiver on");
    @(posedge core_clk);
    factory_test_strap <= 1'b1;
    settle();
    chk(bus_rx_enable, 1'b0, "receiver off in test");
    rd(ADDR_STATUS, 32'h2, 32'h2, "strap seen");
    @(posedge core_clk);
    factory_test_strap <= 1'b0;
    settle();
    @(posedge core_clk);
    mcu_rst_oe <= 1'b0;
    settle();
    mcu_rst_oe <= 1'b1;
    chk(rst_line_oe, 1'b0, "die holds reset after external pull");
    rd(ADDR_CAUSE, 32'h8, 32'h1 << CAUSE_EXT, "external cause");
    wait_lvl(rst_line_oe, 1'b1, (RST_HOLD_TICKS + 8) * TB_TICK, "release after external reset");
    bus(1'b1, ADDR_CTRL, c);
    bus(1'b1, ADDR_WDSVC, 32'(~WD_KEY));
    wait_lvl(rst_line_oe, 1'b0, 8, "watchdog reset");
    rd(ADDR_CAUSE, 32'h2, 32'h2, "watchdog cause kept");
    rd(ADDR_MUX, 32'h7F, 32'h0, "mux cleared");
    rd(ADDR_CTRL, 32'hFFF, 32'h0, "control cleared");
    bus(1'b1, ADDR_CAUSE, 32'hF);
    wait_lvl(rst_line_oe, 1'b1, (RST_HOLD_TICKS + 8) * TB_TICK, "release after watchdog");
    bus(1'b1, ADDR_CTRL, c);
    // service inside the open half of the window, then let the period run out
    repeat (WD_BASE_TICKS * 3 / 5 * TB_TICK) @(posedge core_clk);
    bus(1'b1, ADDR_WDSVC, 32'(WD_KEY));
    repeat ((WD_BASE_TICKS - 50) * TB_TICK) @(posedge core_clk);
    chk(rst_line_oe, 1'b1, "watchdog period not yet over");
    wait_lvl(rst_line_oe, 1'b0, 100 * TB_TICK, "watchdog expiry");
    rd(ADDR_CAUSE, 32'h2, 32'h2, "expiry cause");
    @(posedge core_clk);
    factory_test_strap <= 1'b1;
    wait_lvl(rst_line_oe, 1'b1, (RST_HOLD_TICKS + 8) * TB_TICK, "release into test mode");
    settle();
    chk(bus_rx_enable, 1'b0, "receiver off in test mode");
    chk(sleep_mode, 1'b0, "no sleep in test mode");
    rd(ADDR_STATUS, 32'h3, 32'h2, "test mode not run");
    @(posedge core_clk);
    factory_test_strap <= 1'b0;
    repeat ((NORMREQ_TICKS - 8) * TB_TICK) @(posedge core_clk);
    chk(sleep_mode, 1'b0, "timeout too early");
    wait_lvl(sleep_mode, 1'b1, 24 * TB_TICK, "timeout sleep");
    chk(rst_line_oe, 1'b0, "reset line low in sleep");
    rd(ADDR_IFLAG, 32'h2, 32'h1 << IRQ_TOUT, "timeout flag");
    @(posedge core_clk);
    wake_input <= ~wake_input;
    settle();
    chk(sleep_mode, 1'b0, "wake from sleep");
    rd(ADDR_CAUSE, 32'h4, 32'h1 << CAUSE_WAKE, "wake cause");
    conclude();
  end
endmodule
`default_nettype wire
